// ===== dfd_consts.svh
// Purpose: Encoding constants for the instruction format decoder.
// Assumes: 24-bit program words, opcode in the top byte.
// Notes: Opcode and class codes are local encodings.
`ifndef DFD_CONSTS_SVH
`define DFD_CONSTS_SVH
`define DFD_OPC_LSB 16
`define DFD_OPC_NOP 8'h00
`define DFD_OPC_BRA 8'h01
`define DFD_OPC_CALL2 8'h02
`define DFD_OPC_BRA_COMP 8'h03
`define DFD_OPC_GOTO2 8'h04
`define DFD_OPC_CALL_IND 8'h05
`define DFD_OPC_JMP_IND 8'h06
`define DFD_OPC_TBL_RD 8'h07
`define DFD_OPC_MOVD2 8'h08
`define DFD_OPC_TBL_WR 8'h09
`define DFD_OPC_RET 8'h0A
`define DFD_OPC_RETI 8'h0B
`define DFD_OPC_BRA_COND 8'h0C
`define DFD_OPC_SKIP 8'h0D
`define DFD_CLS_CTRL 3'h0
`define DFD_CLS_LIT 3'h1
`define DFD_CLS_DEFAULT_WORKING_REG_A 3'h2
`define DFD_CLS_DEFAULT_WORKING_REG_B 3'h3
`define DFD_CLS_FILE 3'h4
`define DFD_CLS_BIT 3'h5
`define DFD_CLS_MAC 3'h6
`define DFD_CLS_DSP 3'h7
`define DFD_CYC_ONE 2'h1
`define DFD_CYC_TWO 2'h2
`define DFD_CYC_THREE 2'h3
`define DFD_REG_W0 4'h0
`define DFD_REG_W4 4'h4
`define DFD_REG_W8 4'h8
`define DFD_REG_W10 4'hA
`define DFD_REG_W12 4'hC
`define DFD_REG_W13 4'hD
`define DFD_PF_INDEXED 4'hE
`define DFD_PF_NONE 4'hF
`define DFD_FILE_MAX 13'h1FFF
`define DFD_BYTE_LIT_MAX 10'h0FF
`define DFD_GEN_FLAGS_ALL 5'h1F
`define DFD_GEN_FLAG_Z 5'h01
`define DFD_DSP_FLAGS_A 4'h5
`define DFD_DSP_FLAGS_B 4'hA
`define DFD_RST_GEN_FLAGS 5'h00
`define DFD_RST_DSP_FLAGS 4'h0
`endif

// ===== dfd_pkg.sv
// Purpose: Types shared by the instruction format decoder.
// Assumes: Nothing beyond the constants header.
// Notes: Enumerations only; numbers live in the header.
package dfd_pkg;
  typedef enum logic [2:0] {
    DFD_CLASS_CTRL, DFD_CLASS_LIT, DFD_CLASS_DEFAULT_WORKING_REG, DFD_CLASS_FILE,
    DFD_CLASS_BIT, DFD_CLASS_MAC, DFD_CLASS_DSP, DFD_CLASS_NOP
  } dfd_class_t;
  typedef enum logic [1:0] {DFD_WIDTH_WORD, DFD_WIDTH_BYTE, DFD_WIDTH_DOUBLE} dfd_width_t;
  typedef enum logic [1:0] {DFD_ST_IDLE, DFD_ST_SECOND, DFD_ST_SKIP} dfd_state_t;
endpackage

// ===== dfd_prefetch_decode.sv
// Purpose: Decode a 4-bit X or Y prefetch code into register and step.
// Assumes: BASE_REG is the lower of the two address registers.
// Notes: Pure combinational; the caller registers the outputs.
`include "dfd_consts.svh"
module dfd_prefetch_decode #(
  parameter logic [3:0] BASE_REG = `DFD_REG_W8
) (
  input wire logic [3:0] code_i,
  output logic [3:0] addr_reg_o,
  output logic signed [3:0] step_o,
  output logic indexed_o,
  output logic none_o
);
  logic [2:0] slot;
  always_comb begin
    slot = 3'h0;
    addr_reg_o = BASE_REG;
    step_o = 4'sh0;
    indexed_o = 1'b0;
    none_o = 1'b0;
    if (code_i == `DFD_PF_NONE) begin
      none_o = 1'b1;
    end else if (code_i == `DFD_PF_INDEXED) begin
      // Indexed form uses the upper register plus the index register
      addr_reg_o = BASE_REG + 4'h1;
      indexed_o = 1'b1;
    end else begin
      addr_reg_o = (code_i > 4'h6) ? BASE_REG + 4'h1 : BASE_REG;
      slot = (code_i > 4'h6) ? 3'(code_i - 4'h7) : code_i[2:0];
      unique case (slot)
        3'h0: step_o = 4'sh6;
        3'h1: step_o = 4'sh4;
        3'h2: step_o = 4'sh2;
        3'h3: step_o = 4'sh0;
        3'h4: step_o = -4'sh6;
        3'h5: step_o = -4'sh4;
        3'h6: step_o = -4'sh2;
        default: step_o = 4'sh0;
      endcase
    end
  end
endmodule // dfd_prefetch_decode

// ===== dfd_cycle_counter.sv
// Purpose: Holds off the fetch side for the extra cycles of an instruction.
// Assumes: load_i is a one-cycle pulse from the decoder.
// Notes: A load while counting restarts the count.
module dfd_cycle_counter #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [W-1:0] extra_i,
  output logic stall_o
);
  logic [W-1:0] cnt_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else if (load_i) begin
      cnt_reg <= extra_i;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end
  assign stall_o = (cnt_reg != '0);
endmodule // dfd_cycle_counter

// ===== dfd_decoder.sv
// Purpose: Split program words into opcode and operand fields, set cycles.
// Assumes: Fetch unit on clk_i; next_word_i is the word after word_i.
// Notes: Fields are registered and valid with the dec_valid_o pulse.
`include "dfd_consts.svh"
module dfd_decoder (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic word_valid_i,
  input wire logic [23:0] word_i,
  input wire logic [23:0] next_word_i,
  input wire logic cond_true_i,
  input wire logic exec_flags_valid_i,
  input wire logic [4:0] exec_flags_i,
  input wire logic [3:0] exec_dsp_flags_i,
  output logic word_ready_o,
  output logic dec_valid_o,
  output dfd_pkg::dfd_class_t dec_class_o,
  output dfd_pkg::dfd_width_t dec_width_o,
  output logic [7:0] dec_opcode_o,
  output logic [1:0] cycles_o,
  output logic two_word_o,
  output logic [31:0] long_operand_o,
  output logic second_word_err_o,
  output logic [22:0] program_addr_literal_o,
  output logic addr_lit_err_o,
  output logic [3:0] base_reg_field_o,
  output logic [3:0] source_reg_field_o,
  output logic [2:0] source_mode_o,
  output logic [3:0] dest_reg_field_o,
  output logic [2:0] dest_mode_o,
  output logic [12:0] file_addr_o,
  output logic file_dest_is_f_o,
  output logic [3:0] bit_select_field_o,
  output logic bit_indirect_o,
  output logic [9:0] ten_bit_literal_o,
  output logic [15:0] signed_ten_bit_literal_o,
  output logic lit_range_err_o,
  output logic acc_sel_o,
  output logic [3:0] mul_m_reg_o,
  output logic [3:0] mul_n_reg_o,
  output logic [3:0] x_prefetch_addr_o,
  output logic [3:0] x_pf_step_o,
  output logic x_pf_indexed_o,
  output logic x_pf_none_o,
  output logic [3:0] x_pf_dest_o,
  output logic [3:0] y_prefetch_addr_o,
  output logic [3:0] y_pf_step_o,
  output logic y_pf_indexed_o,
  output logic y_pf_none_o,
  output logic [3:0] y_pf_dest_o,
  output logic [3:0] acc_writeback_dest_o,
  output logic awb_postinc_o,
  output logic shift_by_reg_o,
  output logic [3:0] shift_count_reg_o,
  output logic [4:0] general_flags_o,
  output logic [3:0] dsp_flags_o
);
  import dfd_pkg::*;

  dfd_state_t state_reg;
  logic [23:0] first_reg;
  logic [1:0] skip_left_reg;
  logic [4:0] gen_mask_reg;
  logic [3:0] dsp_mask_reg;
  logic stall;
  logic fire;
  logic emit;
  logic [23:0] dw;
  logic [7:0] opc;
  logic is_two_word;
  logic next_is_two_word;
  logic skip_taken;
  dfd_class_t cls_next;
  dfd_width_t width_next;
  logic [1:0] cycles_next;
  logic [1:0] extra_next;
  logic [4:0] gen_mask_next;
  logic [3:0] dsp_mask_next;
  logic [3:0] xpf_reg, ypf_reg;
  logic signed [3:0] xpf_step, ypf_step;
  logic xpf_idx, ypf_idx, xpf_none, ypf_none;

  function automatic logic two_word_opc(input logic [7:0] op);
    two_word_opc = (op == `DFD_OPC_CALL2) || (op == `DFD_OPC_GOTO2) ||
                   (op == `DFD_OPC_MOVD2);
  endfunction

  assign fire = word_valid_i && word_ready_o;
  assign word_ready_o = !stall;
  assign dw = (state_reg == DFD_ST_SECOND) ? first_reg : word_i;
  assign opc = dw[23:`DFD_OPC_LSB];
  assign is_two_word = two_word_opc(opc);
  assign next_is_two_word = two_word_opc(next_word_i[23:`DFD_OPC_LSB]);
  assign skip_taken = (opc == `DFD_OPC_SKIP) && cond_true_i;
  assign emit = fire && ((state_reg == DFD_ST_SECOND) ||
                         (state_reg == DFD_ST_IDLE && !is_two_word));

  always_comb begin
    cls_next = DFD_CLASS_CTRL;
    gen_mask_next = 5'h00;
    dsp_mask_next = 4'h0;
    unique case (opc[7:5])
      `DFD_CLS_CTRL: cls_next = (opc == `DFD_OPC_NOP) ? DFD_CLASS_NOP : DFD_CLASS_CTRL;
      `DFD_CLS_LIT: cls_next = DFD_CLASS_LIT;
      `DFD_CLS_DEFAULT_WORKING_REG_A, `DFD_CLS_DEFAULT_WORKING_REG_B: cls_next = DFD_CLASS_DEFAULT_WORKING_REG;
      `DFD_CLS_FILE: cls_next = DFD_CLASS_FILE;
      `DFD_CLS_BIT: cls_next = DFD_CLASS_BIT;
      `DFD_CLS_MAC: cls_next = DFD_CLASS_MAC;
      `DFD_CLS_DSP: cls_next = DFD_CLASS_DSP;
    endcase
    // Per-class flag subsets; no-ops and control touch nothing
    unique case (cls_next)
      DFD_CLASS_LIT, DFD_CLASS_DEFAULT_WORKING_REG, DFD_CLASS_FILE: gen_mask_next = `DFD_GEN_FLAGS_ALL;
      DFD_CLASS_BIT: gen_mask_next = `DFD_GEN_FLAG_Z;
      DFD_CLASS_MAC, DFD_CLASS_DSP:
        dsp_mask_next = dw[15] ? `DFD_DSP_FLAGS_B : `DFD_DSP_FLAGS_A;
      DFD_CLASS_CTRL, DFD_CLASS_NOP: gen_mask_next = 5'h00;
    endcase
  end

  // Literal class has no double form, so only the low opcode bit counts
  always_comb begin
    width_next = DFD_WIDTH_WORD;
    unique case ((cls_next == DFD_CLASS_LIT) ? {1'b0, opc[0]} : opc[1:0])
      2'h1: width_next = DFD_WIDTH_BYTE;
      2'h2: width_next = DFD_WIDTH_DOUBLE;
      default: width_next = DFD_WIDTH_WORD;
    endcase
  end

  always_comb begin
    cycles_next = `DFD_CYC_ONE;
    if (is_two_word) begin
      cycles_next = `DFD_CYC_TWO;
    end else begin
      unique case (opc)
        `DFD_OPC_BRA, `DFD_OPC_BRA_COMP, `DFD_OPC_CALL_IND, `DFD_OPC_JMP_IND,
        `DFD_OPC_TBL_RD, `DFD_OPC_TBL_WR: cycles_next = `DFD_CYC_TWO;
        `DFD_OPC_RET, `DFD_OPC_RETI: cycles_next = `DFD_CYC_THREE;
        `DFD_OPC_BRA_COND: cycles_next = cond_true_i ? `DFD_CYC_TWO : `DFD_CYC_ONE;
        `DFD_OPC_SKIP:
          if (cond_true_i) begin
            cycles_next = next_is_two_word ? `DFD_CYC_THREE : `DFD_CYC_TWO;
          end
        default: cycles_next = `DFD_CYC_ONE;
      endcase
    end
    // Skipped words and the second word are real fetch cycles already
    extra_next = (is_two_word || opc == `DFD_OPC_SKIP) ? 2'h0 : cycles_next - 2'h1;
  end

  dfd_cycle_counter #(.W(2)) u_cycles (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(emit),
    .extra_i(extra_next),
    .stall_o(stall)
  );

  dfd_prefetch_decode #(.BASE_REG(`DFD_REG_W8)) u_xpf (
    .code_i(dw[10:7]),
    .addr_reg_o(xpf_reg),
    .step_o(xpf_step),
    .indexed_o(xpf_idx),
    .none_o(xpf_none)
  );

  dfd_prefetch_decode #(.BASE_REG(`DFD_REG_W10)) u_ypf (
    .code_i(dw[6:3]),
    .addr_reg_o(ypf_reg),
    .step_o(ypf_step),
    .indexed_o(ypf_idx),
    .none_o(ypf_none)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= DFD_ST_IDLE;
      first_reg <= 24'h000000;
      skip_left_reg <= 2'h0;
    end else if (fire) begin
      unique case (state_reg)
        DFD_ST_IDLE:
          if (is_two_word) begin
            first_reg <= word_i;
            state_reg <= DFD_ST_SECOND;
          end else if (skip_taken) begin
            skip_left_reg <= next_is_two_word ? 2'h2 : 2'h1;
            state_reg <= DFD_ST_SKIP;
          end
        DFD_ST_SECOND: state_reg <= DFD_ST_IDLE;
        DFD_ST_SKIP: begin
          // Swallowed words never reach the outputs
          skip_left_reg <= skip_left_reg - 2'h1;
          if (skip_left_reg == 2'h1) begin
            state_reg <= DFD_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_valid_o <= 1'b0;
    end else begin
      dec_valid_o <= emit;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_class_o <= DFD_CLASS_NOP;
      dec_width_o <= DFD_WIDTH_WORD;
      dec_opcode_o <= `DFD_OPC_NOP;
      cycles_o <= `DFD_CYC_ONE;
      two_word_o <= 1'b0;
      long_operand_o <= 32'h00000000;
      second_word_err_o <= 1'b0;
      program_addr_literal_o <= 23'h000000;
      addr_lit_err_o <= 1'b0;
      gen_mask_reg <= 5'h00;
      dsp_mask_reg <= 4'h0;
    end else if (emit) begin
      dec_class_o <= cls_next;
      dec_width_o <= width_next;
      dec_opcode_o <= opc;
      cycles_o <= cycles_next;
      two_word_o <= is_two_word;
      gen_mask_reg <= gen_mask_next;
      dsp_mask_reg <= dsp_mask_next;
      if (is_two_word) begin
        long_operand_o <= {word_i[15:0], first_reg[15:0]};
        second_word_err_o <= (word_i[23:`DFD_OPC_LSB] != 8'h00);
        program_addr_literal_o <= {word_i[6:0], first_reg[15:0]};
        addr_lit_err_o <= first_reg[0];
      end else begin
        long_operand_o <= {16'h0000, dw[15:0]};
        second_word_err_o <= 1'b0;
        program_addr_literal_o <= 23'h000000;
        addr_lit_err_o <= 1'b0;
      end
    end
  end

  // Operand fields; layouts overlap, so each class writes its own subset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_reg_field_o <= `DFD_REG_W0;
      source_reg_field_o <= `DFD_REG_W0;
      source_mode_o <= 3'h0;
      dest_reg_field_o <= `DFD_REG_W0;
      dest_mode_o <= 3'h0;
      file_addr_o <= 13'h0000;
      file_dest_is_f_o <= 1'b0;
      bit_select_field_o <= 4'h0;
      bit_indirect_o <= 1'b0;
      ten_bit_literal_o <= 10'h000;
      signed_ten_bit_literal_o <= 16'h0000;
      lit_range_err_o <= 1'b0;
    end else if (emit) begin
      lit_range_err_o <= 1'b0;
      unique case (cls_next)
        DFD_CLASS_DEFAULT_WORKING_REG: begin
          base_reg_field_o <= dw[15:12];
          dest_mode_o <= {1'b0, dw[11:10]};
          dest_reg_field_o <= dw[9:6];
          source_mode_o <= {1'b0, dw[5:4]};
          source_reg_field_o <= dw[3:0];
        end
        DFD_CLASS_FILE: begin
          file_addr_o <= dw[12:0] & `DFD_FILE_MAX;
          file_dest_is_f_o <= dw[13];
          dest_reg_field_o <= `DFD_REG_W0;
        end
        DFD_CLASS_BIT: begin
          bit_select_field_o <= dw[15:12];
          bit_indirect_o <= dw[11];
          base_reg_field_o <= dw[10:7];
          source_mode_o <= dw[6:4];
          source_reg_field_o <= dw[3:0];
        end
        DFD_CLASS_LIT: begin
          base_reg_field_o <= dw[3:0];
          ten_bit_literal_o <= dw[13:4];
          signed_ten_bit_literal_o <= {{6{dw[13]}}, dw[13:4]};
          dest_reg_field_o <= dw[14] ? opc[4:1] : dw[3:0];
          dest_mode_o <= 3'h0;
          lit_range_err_o <= (width_next == DFD_WIDTH_BYTE) &&
                             (dw[13:4] > `DFD_BYTE_LIT_MAX);
        end
        DFD_CLASS_DSP: begin
          source_mode_o <= dw[6:4];
          source_reg_field_o <= dw[3:0];
          dest_mode_o <= dw[6:4];
          dest_reg_field_o <= dw[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_sel_o <= 1'b0;
      mul_m_reg_o <= `DFD_REG_W4;
      mul_n_reg_o <= `DFD_REG_W4;
      x_prefetch_addr_o <= `DFD_REG_W8;
      x_pf_step_o <= 4'h0;
      x_pf_indexed_o <= 1'b0;
      x_pf_none_o <= 1'b1;
      x_pf_dest_o <= `DFD_REG_W4;
      y_prefetch_addr_o <= `DFD_REG_W10;
      y_pf_step_o <= 4'h0;
      y_pf_indexed_o <= 1'b0;
      y_pf_none_o <= 1'b1;
      y_pf_dest_o <= `DFD_REG_W4;
      acc_writeback_dest_o <= `DFD_REG_W13;
      awb_postinc_o <= 1'b0;
      shift_by_reg_o <= 1'b0;
      shift_count_reg_o <= 4'h0;
    end else if (emit && cls_next == DFD_CLASS_MAC) begin
      acc_sel_o <= dw[15];
      mul_m_reg_o <= `DFD_REG_W4 + {2'h0, dw[14:13]};
      // Square form reuses the multiplicand as multiplier
      mul_n_reg_o <= `DFD_REG_W4 + {2'h0, (opc[4] ? dw[14:13] : dw[12:11])};
      x_prefetch_addr_o <= xpf_reg;
      x_pf_step_o <= xpf_step;
      x_pf_indexed_o <= xpf_idx;
      x_pf_none_o <= xpf_none;
      x_pf_dest_o <= `DFD_REG_W4 + {2'h0, opc[3:2]};
      y_prefetch_addr_o <= ypf_reg;
      y_pf_step_o <= ypf_step;
      y_pf_indexed_o <= ypf_idx;
      y_pf_none_o <= ypf_none;
      y_pf_dest_o <= `DFD_REG_W4 + {2'h0, opc[1:0]};
      acc_writeback_dest_o <= `DFD_REG_W13;
      awb_postinc_o <= dw[2];
    end else if (emit && cls_next == DFD_CLASS_DSP) begin
      acc_sel_o <= dw[15];
      shift_by_reg_o <= dw[14];
      shift_count_reg_o <= dw[13:10];
    end
  end

  // Flags follow the mask of the last decoded instruction
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      general_flags_o <= `DFD_RST_GEN_FLAGS;
      dsp_flags_o <= `DFD_RST_DSP_FLAGS;
    end else if (exec_flags_valid_i) begin
      general_flags_o <= (general_flags_o & ~gen_mask_reg) |
                         (exec_flags_i & gen_mask_reg);
      dsp_flags_o <= (dsp_flags_o & ~dsp_mask_reg) |
                     (exec_dsp_flags_i & dsp_mask_reg);
    end
  end

  chk_opcode_top: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (fire && state_reg == DFD_ST_IDLE && !is_two_word) |=>
      dec_valid_o && dec_opcode_o == $past(word_i[23:16]))
    else $error("opcode not taken from top byte");
  chk_two_word_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (fire && state_reg == DFD_ST_IDLE && is_two_word) |=>
      !dec_valid_o && state_reg == DFD_ST_SECOND)
    else $error("two-word first half emitted early");
  chk_second_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (fire && state_reg == DFD_ST_SECOND) |=>
      two_word_o && second_word_err_o == ($past(word_i[23:16]) != 8'h00))
    else $error("second word check wrong");
  chk_lone_nop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dec_valid_o && dec_opcode_o == 8'h00) |-> dec_class_o == DFD_CLASS_NOP &&
      cycles_o == 2'h1 && gen_mask_reg == 5'h00 && dsp_mask_reg == 4'h0)
    else $error("lone second word not a no-op");
  chk_cond_branch: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (emit && opc == 8'h0C) |=> cycles_o == ($past(cond_true_i) ? 2'h2 : 2'h1))
    else $error("conditional branch cycles wrong");
  chk_stall_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dec_valid_o && cycles_o == 2'h3 && dec_opcode_o != 8'h0D) |->
      !word_ready_o [*2] ##1 word_ready_o)
    else $error("three-cycle stall length wrong");
  chk_skip_words: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dec_valid_o && dec_opcode_o == 8'h0D && cycles_o != 2'h1) |->
      state_reg == DFD_ST_SKIP && skip_left_reg == cycles_o - 2'h1)
    else $error("skip swallow count wrong");
  chk_two_word_cyc: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dec_valid_o && two_word_o) |-> cycles_o == 2'h2 && word_ready_o)
    else $error("two-word cycle count wrong");
  chk_lit_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (dec_valid_o && dec_class_o == DFD_CLASS_LIT) |-> lit_range_err_o ==
      (dec_width_o == DFD_WIDTH_BYTE && ten_bit_literal_o > 10'h0FF))
    else $error("byte literal range flag wrong");
  chk_square_reg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (emit && cls_next == DFD_CLASS_MAC && opc[4]) |=>
      mul_m_reg_o == mul_n_reg_o && mul_m_reg_o >= 4'h4 && mul_m_reg_o <= 4'h7)
    else $error("square register pair wrong");
  chk_flag_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (exec_flags_valid_i && gen_mask_reg == 5'h00 && dsp_mask_reg == 4'h0) |=>
      $stable(general_flags_o) && $stable(dsp_flags_o))
    else $error("flags changed under empty mask");

  cov_two_word: cover property (@(posedge clk_i) disable iff (!resetn_i)
    dec_valid_o && two_word_o);
  cov_skip_three: cover property (@(posedge clk_i) disable iff (!resetn_i)
    dec_valid_o && dec_opcode_o == 8'h0D && cycles_o == 2'h3);
  cov_return: cover property (@(posedge clk_i) disable iff (!resetn_i)
    dec_valid_o && dec_opcode_o == 8'h0B);
  cov_mac: cover property (@(posedge clk_i) disable iff (!resetn_i)
    dec_valid_o && dec_class_o == DFD_CLASS_MAC && awb_postinc_o);
endmodule // dfd_decoder

// ===== dfd_fetch_model.sv
// Purpose: Fetch unit model offering queued program words.
// Assumes: Bench fills q; ready_i is the decoder's word_ready_o.
// Notes: Idle word lines invert each cycle so a stale word never matches.
module dfd_fetch_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o = 1'b0,
  output logic [23:0] word_o = 24'h000000,
  output logic [23:0] next_o = 24'h000000
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] q[$];
  always @(posedge clk_i) begin
    if (valid_o && ready_i) void'(q.pop_front());
    #1;
    valid_o = q.size() > 0;
    word_o = valid_o ? q[0] : ~word_o;
    next_o = (q.size() > 1) ? q[1] : ~next_o;
  end
endmodule // dfd_fetch_model

// ===== dsp_instruction_format_decoder_bench.sv
// Purpose: Self-checking bench for the instruction format decoder.
// Assumes: 5 ns clock; inputs move 1 ns after each rising edge.
// Notes: Expectations follow the local opcode encoding.
`include "dfd_consts.svh"
module dsp_instruction_format_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dfd_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, ct = 1'b0, efv = 1'b0;
  logic wv, rdy, dv, two, swe, fdf;
  logic [23:0] w, nw;
  logic [31:0] lop;
  logic [12:0] fa;
  logic [7:0] opc;
  logic [4:0] ef = 5'h00, gf;
  logic [3:0] edf = 4'h0, dspf;
  logic [1:0] cyc;
  dfd_class_t cls;
  dfd_width_t wdt;
  logic ale, bin, lre, acs, xpn, ypi, awbp, sbr;
  logic [22:0] pal;
  logic [9:0] tl;
  logic [15:0] stl;
  logic [3:0] brf, srf, drf, bsf, mm, mn, xpa, xps, xpd, ypa, ypd, awd, scr;
  logic [2:0] smd, dmd;
  int num_errors = 0, n_compared = 0;
  dfd_fetch_model fm (.clk_i(clk_i), .ready_i(rdy), .valid_o(wv), .word_o(w), .next_o(nw));
  dfd_decoder uut (.clk_i(clk_i), .resetn_i(resetn_i), .word_valid_i(wv), .word_i(w),
    .next_word_i(nw), .cond_true_i(ct), .exec_flags_valid_i(efv), .exec_flags_i(ef),
    .exec_dsp_flags_i(edf), .word_ready_o(rdy), .dec_valid_o(dv), .dec_class_o(cls),
    .dec_width_o(wdt), .dec_opcode_o(opc), .cycles_o(cyc), .two_word_o(two),
    .long_operand_o(lop), .second_word_err_o(swe), .program_addr_literal_o(pal),
    .addr_lit_err_o(ale), .base_reg_field_o(brf), .source_reg_field_o(srf),
    .source_mode_o(smd), .dest_reg_field_o(drf), .dest_mode_o(dmd), .file_addr_o(fa),
    .file_dest_is_f_o(fdf), .bit_select_field_o(bsf), .bit_indirect_o(bin),
    .ten_bit_literal_o(tl), .signed_ten_bit_literal_o(stl), .lit_range_err_o(lre),
    .acc_sel_o(acs), .mul_m_reg_o(mm), .mul_n_reg_o(mn), .x_prefetch_addr_o(xpa),
    .x_pf_step_o(xps), .x_pf_indexed_o(), .x_pf_none_o(xpn), .x_pf_dest_o(xpd),
    .y_prefetch_addr_o(ypa), .y_pf_step_o(), .y_pf_indexed_o(ypi), .y_pf_none_o(),
    .y_pf_dest_o(ypd), .acc_writeback_dest_o(awd), .awb_postinc_o(awbp),
    .shift_by_reg_o(sbr), .shift_count_reg_o(scr), .general_flags_o(gf),
    .dsp_flags_o(dspf));
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wt();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i) #1;
      if (dv === 1'b1) break;
    end
    cmp(dv, 1'b1);
  endtask
  task automatic dec(input logic [23:0] wd);
    fm.q.push_back(wd);
    wt();
  endtask
  // Pulses the flag strobe for one cycle, then checks both flag outputs
  task automatic flg(input logic [4:0] g, input logic [3:0] d, input logic [4:0] eg,
    input logic [3:0] ed);
    efv = 1'b1;
    ef = g;
    edf = d;
    @(posedge clk_i) #1;
    efv = 1'b0;
    cmp(gf, eg);
    cmp(dspf, ed);
  endtask
  task automatic t_fields();
    ct = 1'b0;
    dec(24'h0C0000);
    cmp(cyc, `DFD_CYC_ONE);
    cmp(rdy, 1'b1);
    dec(24'h0D0000);
    cmp(cyc, `DFD_CYC_ONE);
    dec(24'h010000);
    cmp(opc, `DFD_OPC_BRA);
    dec(24'h413666);
    cmp(wdt, DFD_WIDTH_BYTE);
    cmp({brf, drf, srf}, 12'h396);
    cmp({dmd, smd}, 6'h0A);
    flg(5'h15, 4'hF, 5'h15, 4'h0);
    dec(24'h2A7F02);
    cmp(wdt, DFD_WIDTH_WORD);
    cmp({tl, stl}, 26'h3F0FFF0);
    cmp({brf, drf, lre}, 9'h04A);
    dec(24'h211FF5);
    cmp({tl, lre}, 11'h3FF);
    cmp({brf, drf}, 8'h55);
    dec(24'hA0CB80);
    cmp({bsf, bin, brf}, 9'h197);
    flg(5'h0A, 4'hF, 5'h14, 4'h0);
    dec(24'hC6DCF4);
    cmp({acs, mm, mn}, 9'h167);
    cmp({xpa, xps, xpd}, 12'h925);
    cmp({ypa, ypd}, 8'hB6);
    cmp({ypi, awbp}, 2'h3);
    cmp(awd, `DFD_REG_W13);
    flg(5'h00, 4'hF, 5'h14, 4'hA);
    dec(24'hD327F8);
    cmp({mm, mn, xpn, acs}, 10'h156);
    dec(24'hE0EC34);
    cmp({acs, sbr, scr, srf}, 10'h3B4);
    dec(24'h000000);
    flg(5'h1F, 4'hF, 5'h14, 4'hA);
    fm.q.push_back(24'h041235);
    dec(24'h00007F);
    cmp({ale, pal}, 24'hFF1235);
  endtask
  task automatic t_ctrl();
    logic [7:0] op[9] = '{8'h0C, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B};
    ct = 1'b1;
    foreach (op[k]) begin
      fm.q.push_back({op[k], 16'h0000});
      wt();
      cmp(cyc, (k > 6) ? `DFD_CYC_THREE : `DFD_CYC_TWO);
      cmp(rdy, 1'b0);
    end
  endtask
  task automatic t_two();
    fm.q.push_back(24'h021234);
    fm.q.push_back(24'h005678);
    wt();
    cmp(two, 1'b1);
    cmp(cyc, `DFD_CYC_TWO);
    cmp(lop, 32'h56781234);
    fm.q.push_back(24'h081111);
    fm.q.push_back(24'h0F2222);
    wt();
    cmp(swe, 1'b1);
    fm.q.push_back(24'h005678);
    wt();
    cmp(cls, DFD_CLASS_NOP);
    fm.q.push_back(24'h803FFF);
    wt();
    cmp(fa, `DFD_FILE_MAX);
    cmp(fdf, 1'b1);
  endtask
  // Second skip peeks a one-word follower, first a two-word one
  task automatic t_skip();
    ct = 1'b1;
    fm.q.push_back(24'h0D0000);
    fm.q.push_back(24'h04AAAA);
    fm.q.push_back(24'h00BBBB);
    fm.q.push_back(24'h0D0000);
    fm.q.push_back(24'h40F000);
    fm.q.push_back(24'h0A0000);
    wt();
    cmp(cyc, `DFD_CYC_THREE);
    wt();
    cmp(cyc, `DFD_CYC_TWO);
    wt();
    cmp(opc, 8'h0A);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_ctrl();
    t_two();
    t_skip();
    t_fields();
    end_sim();
  end
endmodule // dsp_instruction_format_decoder_bench
